// >>> pdc_host.sv
// Purpose: Host controller that drives a 16-bit parallel-input converter through its pins.
// Assumes: Pins are synchronous to sys_clk_i; software talks over classic Wishbone.
// Notes: The converter itself is outside; this block only sequences its pins.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
module pdc_host import pdc_pkg::*; #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter data port
  input wire logic [DATA_W-1:0] dac_data_i,
  output logic [DATA_W-1:0] dac_data_o,
  output logic dac_data_oe_n_o,
  // Converter control pins
  output logic dac_select_n_o,
  output logic dac_read_write_o,
  output logic output_load_strobe_o,
  output logic output_reset_strobe_o,
  output logic reset_level_select_o,
  output logic powerdown_select_hi_o,
  output logic powerdown_select_lo_o,
  output logic code_format_select_o
);
  pdc_state_t state, next_state;
  logic [3:0] ctrl;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic [7:0] tcnt;
  logic do_read, do_load, do_reset;
  logic ack;
  logic pd_prev;
  logic wake_busy;

  wire bus_req = wb_cyc_i && wb_stb_i && !ack;
  wire wr_req = bus_req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wr_req && (wb_adr_i == ADR_CTRL);
  wire wr_data_reg = wr_req && (wb_adr_i == ADR_DATA);
  wire wr_cmd = wr_req && (wb_adr_i == ADR_CMD) && (state == PDC_IDLE);
  wire busy = (state != PDC_IDLE);
  wire pd_now = ctrl[CTRL_PD_HI_BIT] | ctrl[CTRL_PD_LO_BIT];
  wire wake_start = pd_prev && !pd_now;
  wire tdone = (tcnt == 8'(STROBE_CYCLES - 1));
  wire [3:0] cmd = wb_dat_i[3:0];

  // Read mux; unmapped addresses read as zero.
  wire [31:0] rd_mux =
    (wb_adr_i == ADR_CTRL) ? {28'h0000000, ctrl} :
    (wb_adr_i == ADR_DATA) ? {16'h0000, wr_data} :
    (wb_adr_i == ADR_CMD) ? {16'h0000, rd_data} :
    (wb_adr_i == ADR_STAT) ? {30'h00000000, wake_busy, busy} : 32'h00000000;

  pdc_delay #(.COUNT(WAKE_CYCLES)) u_wake (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .start_i(wake_start),
    .busy_o(wake_busy)
  );

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack;

  // Mode pins are static levels that software may change at any time.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= CTRL_RESET;
      wr_data <= 16'h0000;
      pd_prev <= 1'b0;
    end else begin
      pd_prev <= pd_now;
      if (wr_ctrl) begin
        ctrl <= wb_dat_i[3:0];
      end
      if (wr_data_reg) begin
        wr_data <= wb_dat_i[DATA_W-1:0];
      end
    end
  end
  assign reset_level_select_o = ctrl[CTRL_RESET_LEVEL_SELECT_BIT];
  assign powerdown_select_hi_o = ctrl[CTRL_PD_HI_BIT];
  assign powerdown_select_lo_o = ctrl[CTRL_PD_LO_BIT];
  assign code_format_select_o = ctrl[CTRL_FMT_BIT];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= PDC_IDLE;
      tcnt <= 8'h00;
      do_read <= 1'b0;
      do_load <= 1'b0;
      do_reset <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      state <= next_state;
      tcnt <= (next_state != state) ? 8'h00 : tcnt + 8'h01;
      if (wr_cmd) begin
        do_read <= cmd[CMD_READ_BIT];
        do_load <= cmd[CMD_LOAD_BIT];
        do_reset <= cmd[CMD_RESET_BIT];
      end
      if (state == PDC_HOLD && do_read && tdone) begin
        rd_data <= dac_data_i;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PDC_IDLE: begin
        if (wr_cmd && (cmd[CMD_WRITE_BIT] || cmd[CMD_READ_BIT])) begin
          next_state = PDC_SETUP;
        end else if (wr_cmd && cmd[CMD_LOAD_BIT]) begin
          next_state = PDC_LOAD;
        end else if (wr_cmd && cmd[CMD_RESET_BIT]) begin
          next_state = PDC_RST;
        end
      end
      PDC_SETUP: if (tdone) next_state = PDC_SEL;
      PDC_SEL: if (tdone) next_state = PDC_HOLD;
      PDC_HOLD: begin
        if (tdone) begin
          next_state = do_load ? PDC_LOAD : (do_reset ? PDC_RST : PDC_GAP);
        end
      end
      PDC_LOAD: if (tdone) next_state = do_reset ? PDC_RST : PDC_GAP;
      PDC_RST: if (tdone) next_state = PDC_GAP;
      PDC_GAP: if (tdone) next_state = PDC_IDLE;
      default: next_state = PDC_IDLE;
    endcase
  end

  // Select pulses low through SEL and HOLD; write data is driven from SETUP through HOLD.
  wire in_xfer = (state == PDC_SETUP) || (state == PDC_SEL) || (state == PDC_HOLD);
  assign dac_select_n_o = !((state == PDC_SEL) || (state == PDC_HOLD));
  assign dac_read_write_o = in_xfer && do_read;
  assign dac_data_oe_n_o = !(in_xfer && !do_read);
  assign dac_data_o = wr_data;
  assign output_load_strobe_o = (state == PDC_LOAD) && tcnt[1];
  assign output_reset_strobe_o = (state == PDC_RST) && tcnt[1];

  property p_sel_pulse;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $fell(dac_select_n_o) |-> !dac_select_n_o [*8] ##1 dac_select_n_o;
  endproperty
  a_sel_pulse: assert property (p_sel_pulse) else $error("select pulse length wrong");

  property p_data_stable;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !dac_select_n_o && !dac_read_write_o |-> !dac_data_oe_n_o && $stable(dac_data_o);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("write data not held");

  property p_load_after_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(output_load_strobe_o) |-> dac_select_n_o && $past(state, 3) != PDC_SEL;
  endproperty
  a_load_after_write: assert property (p_load_after_write) else $error("load overlaps select");

  property p_reset_edge;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(output_reset_strobe_o) |-> output_reset_strobe_o [*2] ##1 !output_reset_strobe_o;
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("reset strobe shape wrong");

  property p_rst_sel_stable;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      output_reset_strobe_o |-> reset_level_select_o == ctrl[CTRL_RESET_LEVEL_SELECT_BIT];
  endproperty
  a_rst_sel_stable: assert property (p_rst_sel_stable) else $error("reset level wrong");

  property p_wake;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      wake_start |=> wake_busy;
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay not started");

  property p_read_no_drive;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      dac_read_write_o |-> dac_data_oe_n_o;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("bus driven during read");

  property p_idle_float;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      state == PDC_IDLE |-> dac_select_n_o && dac_data_oe_n_o && !output_load_strobe_o;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("pins active while idle");
endmodule // pdc_host

// >>> pdc_pkg.sv
// Purpose: Shared constants for the parallel converter host controller.
// Assumes: 200 MHz system clock, classic Wishbone register port.
// Notes: Register offsets are byte addresses of 32-bit words.
package pdc_pkg;
  localparam int SYS_CLK_MHZ = 200;
  localparam int WAKE_DELAY_NS = 2500;
  localparam int WAKE_CYCLES = (WAKE_DELAY_NS * SYS_CLK_MHZ) / 1000;
  localparam int STROBE_CYCLES = 4;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_DATA = 4'h4;
  localparam logic [3:0] ADR_CMD = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hC;
  localparam int CTRL_RESET_LEVEL_SELECT_BIT = 0;
  localparam int CTRL_PD_LO_BIT = 1;
  localparam int CTRL_PD_HI_BIT = 2;
  localparam int CTRL_FMT_BIT = 3;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int CMD_READ_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] MIN_SCALE_USB = 16'h0000;
  localparam logic [15:0] MIN_SCALE_BTC = 16'h8000;
  localparam logic [15:0] MID_SCALE_USB = 16'h8000;
  localparam logic [15:0] MID_SCALE_BTC = 16'h0000;
  localparam logic [15:0] FULL_SCALE_BTC = 16'h7FFF;
  typedef enum logic [6:0] {
    PDC_IDLE = 7'h01,
    PDC_SETUP = 7'h02,
    PDC_SEL = 7'h04,
    PDC_HOLD = 7'h08,
    PDC_LOAD = 7'h10,
    PDC_RST = 7'h20,
    PDC_GAP = 7'h40
  } pdc_state_t;
endpackage

// >>> pdc_delay.sv
// Purpose: Counts a fixed wait after a start pulse.
// Assumes: Start is a one-cycle pulse in the system clock domain.
// Notes: A new start restarts the wait.
module pdc_delay import pdc_pkg::*; #(
  parameter int COUNT = 500
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  output logic busy_o
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
    end else if (start_i) begin
      cnt <= CW'(COUNT);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end
  assign busy_o = (cnt != '0);
endmodule // pdc_delay

// >>> pdc_dev_model.sv
// Purpose: Behavioural model of the parallel-input converter that the host controller drives.
// Assumes: Pins are ideal; the model reacts to pin edges and levels only.
// Notes: Codes pass through unchanged, so the coding choice shows only in reset codes.
module pdc_dev_model import pdc_pkg::*; (
  // Data port
  input wire logic [15:0] bus_i,
  output logic [15:0] bus_o,
  output logic drive_n_o,
  // Control pins
  input wire logic select_n_i,
  input wire logic read_write_i,
  input wire logic load_i,
  input wire logic reset_i,
  input wire logic level_sel_i,
  input wire logic pd_hi_i,
  input wire logic pd_lo_i,
  input wire logic format_i,
  // Observation
  output logic [15:0] in_reg_o,
  output logic [15:0] out_reg_o,
  output logic amp_on_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] pend;
  initial out_reg_o = MIN_SCALE_USB;
  initial in_reg_o = 16'h0000;
  always @(negedge select_n_i) if (!read_write_i) pend = bus_i;
  always @(posedge select_n_i) if (!read_write_i) in_reg_o = pend;
  always @(posedge load_i) out_reg_o = in_reg_o;
  // Reset edges act whatever the power-down state; the input register is left alone.
  always @(posedge reset_i) begin
    out_reg_o = level_sel_i ? (format_i ? MID_SCALE_BTC : MID_SCALE_USB) :
                (format_i ? MIN_SCALE_BTC : MIN_SCALE_USB);
  end
  assign drive_n_o = !(!select_n_i && read_write_i);
  assign bus_o = in_reg_o;
  assign amp_on_o = !(pd_hi_i || pd_lo_i);
endmodule // pdc_dev_model

// >>> pdc_host_tb.sv
// Purpose: Self-checking bench for the host controller against the converter model.
// Assumes: 200 MHz clock, classic Wishbone master tasks.
// Notes: A released data bus shows a pattern that flips every cycle.
module pdc_host_tb import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, ack_dat;
  logic [15:0] d, prev, idle_pat = 16'hA5A5, dev_bus, in_reg, out_reg, dout;
  logic [31:0] rdat;
  logic ack, oe_n, sel_n, rw, ld, rst, rsel, pdh, pdl, fmt, dev_drv_n, amp_on, rs;
  int miscompares = 0, n_compared = 0, cyc_n;
  wire [15:0] bus = !oe_n ? dout : (!dev_drv_n ? dev_bus : idle_pat);
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) idle_pat <= ~idle_pat;
  pdc_host DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .dac_data_i(bus), .dac_data_o(dout), .dac_data_oe_n_o(oe_n),
    .dac_select_n_o(sel_n), .dac_read_write_o(rw), .output_load_strobe_o(ld),
    .output_reset_strobe_o(rst), .reset_level_select_o(rsel), .powerdown_select_hi_o(pdh),
    .powerdown_select_lo_o(pdl), .code_format_select_o(fmt));
  pdc_dev_model u_dev (.bus_i(bus), .bus_o(dev_bus), .drive_n_o(dev_drv_n), .select_n_i(sel_n),
    .read_write_i(rw), .load_i(ld), .reset_i(rst), .level_sel_i(rsel), .pd_hi_i(pdh),
    .pd_lo_i(pdl), .format_i(fmt), .in_reg_o(in_reg), .out_reg_o(out_reg), .amp_on_o(amp_on));
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= dv;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      end_sim();
    end
  endtask
  // Polls status until the given bit clears; cyc_n returns the cycles spent.
  task automatic wait_clear(input int b);
    int n, t0;
    n = 0;
    t0 = $time;
    do begin
      wb(1'b0, ADR_STAT, 32'h0);
      n++;
    end while (q[b] !== 1'b0 && n < 400);
    cyc_n = ($time - t0) / 5;
    if (n >= 400) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    wb(1'b1, ADR_CMD, {28'h0, c});
    wait_clear(STAT_BUSY_BIT);
  endtask
  function automatic logic [15:0] rcode(input logic s, input logic f);
    return s ? (f ? MID_SCALE_BTC : MID_SCALE_USB) : (f ? MIN_SCALE_BTC : MIN_SCALE_USB);
  endfunction
  initial begin
    void'($urandom(32'h60e92fce));
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    prev = MIN_SCALE_USB;
    @(posedge sys_clk_i);
    chk(out_reg, MIN_SCALE_USB);
    for (int i = 0; i < 4; i++) begin
      d = (i == 1) ? 16'h7FFF : 16'($urandom);
      wb(1'b1, ADR_CTRL, {28'h0, i[1], 2'b00, i[0]});
      chk({fmt, pdh, pdl, rsel}, {i[1], 2'b00, i[0]});
      wb(1'b1, ADR_DATA, {16'h0, d});
      cmd(4'h1);
      chk(in_reg, d);
      chk(out_reg, prev);
      cmd(4'h8);
      wb(1'b0, ADR_CMD, 32'h0);
      chk(q[15:0], d);
      cmd(4'h2);
      chk(out_reg, d);
      cmd(4'h4);
      prev = rcode(i[0], i[1]);
      chk(out_reg, prev);
      chk(in_reg, d);
    end
    for (int m = 1; m < 4; m++) begin
      rs = m[0];
      wb(1'b1, ADR_CTRL, {29'h0, m[1:0], rs});
      chk({pdh, pdl, amp_on}, {m[1:0], 1'b0});
      chk(out_reg, prev);
      cmd(4'h4);
      prev = rcode(rs, 1'b0);
      chk(out_reg, prev);
      wb(1'b1, ADR_CTRL, {31'h0, rs});
      wb(1'b0, ADR_STAT, 32'h0);
      chk(q[STAT_WAKE_BIT], 1'b1);
      wait_clear(STAT_WAKE_BIT);
      chk(cyc_n > WAKE_CYCLES - 20 && cyc_n < WAKE_CYCLES + 10, 1'b1);
      chk({amp_on, out_reg}, {1'b1, prev});
    end
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    end_sim();
  end
endmodule // pdc_host_tb
